// ---- logic/csmb_bank.sv ----
// read-only per-channel monitor register bank
// Summary of operation
// - remote setting monitor from 0x03CC, clamped to limiter
// - single flags read 0 off, 1 on
// - event four flag word per channel from 0x050C
// - rise-completion event three flag never turns on
// - modbus output state in bits 0 to 3
// - digit form puts output n in digit n
// - output bits valid only for time-proportional outputs
// - min:sec soak up to 11999 s or 199:59
// - hrs:min soak up to 5999 min or 99:59
// - soak encoding follows configured soak unit
`timescale 1ns/1ps
module csmb_bank
  import csmb_pkg::*;
#(
  parameter int unsigned CHANNELS     = 64,               // channels with flags and values
  parameter int unsigned OUT_CHANNELS = 16                // channels with output state
) (
  input  wire logic                             clock_in,            // 25 MHz clock
  input  wire logic                             sys_rst_in,          // synchronous reset, high
  input  wire csmb_pkg::csmb_req_s              host_req_in,         // host access
  input  wire logic [CHANNELS-1:0][15:0]        remote_setting_in,   // raw remote setting values
  input  wire logic signed [15:0]               limiter_low_in,      // setting limiter low
  input  wire logic signed [15:0]               limiter_high_in,     // setting limiter high
  input  wire logic [CHANNELS-1:0]              sensor_open_in,      // burnout per channel
  input  wire logic [CHANNELS-1:0]              event_one_in,        // event one per channel
  input  wire logic [CHANNELS-1:0]              event_two_in,        // event two per channel
  input  wire logic [CHANNELS-1:0]              event_three_in,      // event three per channel
  input  wire logic [CHANNELS-1:0]              event_three_rise_in, // event three is rise completion
  input  wire logic [CHANNELS-1:0]              event_four_in,       // event four per channel
  input  wire logic [CHANNELS-1:0]              heater_break_in,     // heater break alarm per channel
  input  wire logic [OUT_CHANNELS-1:0][3:0]     output_on_in,        // output levels 1..4
  input  wire logic [OUT_CHANNELS-1:0][3:0]     time_prop_in,        // output is time-proportional
  input  wire logic [CHANNELS-1:0][15:0]        soak_count_in,       // soak time in selected unit
  input  wire logic [CHANNELS-1:0]              soak_unit_hm_in,     // 1: hrs:min, 0: min:sec
  output csmb_pkg::csmb_rsp_s                   host_rsp_out         // registered answer
);
  import csmb_pkg::*;

  // elaboration-time range check
  if (CHANNELS < 1 || CHANNELS > 64 || OUT_CHANNELS < 1 || OUT_CHANNELS > 16) begin : g_bad
    $error("channel counts outside the address map");
  end

  // whole state of the block
  typedef struct packed {
    csmb_rsp_s rsp;                                       // answer register
  } csmb_state_s;

  csmb_state_s state_q;                                   // registered state
  csmb_state_s state_d;                                   // next state

  // region of a word address
  function automatic csmb_region_e region_of(input logic [15:0] a);
    if (a >= RS_BASE   && a < RS_BASE   + 16'(CHANNELS))     return CSMB_R_RS;
    if (a >= OPEN_BASE && a < OPEN_BASE + 16'(CHANNELS))     return CSMB_R_OPEN;
    if (a >= EV1_BASE  && a < EV1_BASE  + 16'(CHANNELS))     return CSMB_R_EV1;
    if (a >= EV2_BASE  && a < EV2_BASE  + 16'(CHANNELS))     return CSMB_R_EV2;
    if (a >= EV3_BASE  && a < EV3_BASE  + 16'(CHANNELS))     return CSMB_R_EV3;
    if (a >= EV4_BASE  && a < EV4_BASE  + 16'(CHANNELS))     return CSMB_R_EV4;
    if (a >= HBA_BASE  && a < HBA_BASE  + 16'(CHANNELS))     return CSMB_R_HBA;
    if (a >= OUT_BASE  && a < OUT_BASE  + 16'(OUT_CHANNELS)) return CSMB_R_OUT;
    if (a >= SOAK_BASE && a < SOAK_BASE + 16'(CHANNELS))     return CSMB_R_SOAK;
    return CSMB_R_NONE;
  endfunction

  // base address of a region
  function automatic logic [15:0] base_of(input csmb_region_e r);
    unique case (r)
      CSMB_R_RS:   return RS_BASE;
      CSMB_R_OPEN: return OPEN_BASE;
      CSMB_R_EV1:  return EV1_BASE;
      CSMB_R_EV2:  return EV2_BASE;
      CSMB_R_EV3:  return EV3_BASE;
      CSMB_R_EV4:  return EV4_BASE;
      CSMB_R_HBA:  return HBA_BASE;
      CSMB_R_OUT:  return OUT_BASE;
      CSMB_R_SOAK: return SOAK_BASE;
      default:     return WORD_ZERO;
    endcase
  endfunction

  // flag word from a single bit
  function automatic logic [15:0] flag_word(input logic f);
    return f ? WORD_ONE : WORD_ZERO;
  endfunction

  csmb_region_e region;                                   // decoded region of request
  logic [5:0]   chan;                                     // channel index within region
  logic [15:0]  offs;                                     // address minus region base
  logic [3:0]   outs;                                     // gated output bits
  logic [15:0]  soak_lim;                                 // clamped soak count
  logic [15:0]  soak_hi;                                  // upper field of soak time
  logic [15:0]  soak_lo;                                  // lower field of soak time
  logic [15:0]  out_digits;                               // output state in digit form
  logic [15:0]  word;                                     // selected read word

  // address decode
  always_comb begin
    region = region_of(host_req_in.addr);
    offs   = host_req_in.addr - base_of(region);
    chan   = offs[5:0];
  end

  // output state, masked to time-proportional outputs
  always_comb begin
    outs       = '0;
    out_digits = WORD_ZERO;
    if (region == CSMB_R_OUT) begin
      outs = output_on_in[chan[3:0]] & time_prop_in[chan[3:0]];
    end
    for (int i = 0; i < OUT_BITS; i++) begin
      out_digits[i*DIGIT_W +: DIGIT_W] = {3'h0, outs[i]};
    end
  end

  // soak time clamp and split by configured unit
  always_comb begin
    soak_lim = soak_count_in[chan];
    if (soak_unit_hm_in[chan]) begin
      if (soak_lim > SOAK_MAX_MIN) soak_lim = SOAK_MAX_MIN;
    end else begin
      if (soak_lim > SOAK_MAX_SEC) soak_lim = SOAK_MAX_SEC;
    end
    soak_hi = soak_lim / SOAK_RADIX;
    soak_lo = soak_lim % SOAK_RADIX;
  end

  // read word selection
  always_comb begin
    word = WORD_ZERO;
    unique case (region)
      CSMB_R_RS: begin
        word = remote_setting_in[chan];
        if ($signed(word) < limiter_low_in)  word = limiter_low_in;
        if ($signed(word) > limiter_high_in) word = limiter_high_in;
      end
      CSMB_R_OPEN: word = flag_word(sensor_open_in[chan]);
      CSMB_R_EV1:  word = flag_word(event_one_in[chan]);
      CSMB_R_EV2:  word = flag_word(event_two_in[chan]);
      CSMB_R_EV3:  word = flag_word(event_three_in[chan] & ~event_three_rise_in[chan]);
      CSMB_R_EV4:  word = flag_word(event_four_in[chan]);
      CSMB_R_HBA:  word = flag_word(heater_break_in[chan]);
      CSMB_R_OUT:  word = host_req_in.digit_mode ? out_digits : {12'h000, outs};
      CSMB_R_SOAK: begin
        if (host_req_in.digit_mode) begin
          word = 16'(soak_hi * DIGIT_SCALE + soak_lo);
        end else begin
          word = soak_lim;
        end
      end
      default:     word = WORD_ZERO;                          // unmapped reads zero
    endcase
  end

  // next state: answer one cycle after the strobe
  always_comb begin
    state_d                = state_q;
    state_d.rsp.valid      = host_req_in.rd;
    state_d.rsp.error      = (host_req_in.rd | host_req_in.wr) && region == CSMB_R_NONE;
    state_d.rsp.wr_ignored = host_req_in.wr;
    if (host_req_in.rd) begin
      state_d.rsp.data = word;
    end
  end

  // state register
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign host_rsp_out = state_q.rsp;

  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_read_of(csmb_region_e r);
    host_req_in.rd && region == r;
  endsequence

  a_rs_within_limits: assert property (s_read_of(CSMB_R_RS) ##1 host_rsp_out.valid |->
    ($signed(host_rsp_out.data) >= $past(limiter_low_in) && $signed(host_rsp_out.data) <= $past(limiter_high_in))
    || $past(limiter_low_in) > $past(limiter_high_in))
    else $error("remote setting outside limiter");
  a_flag_is_bit: assert property (s_read_of(CSMB_R_OPEN) or s_read_of(CSMB_R_HBA) |=>
    host_rsp_out.data <= WORD_ONE)
    else $error("flag word not 0 or 1");
  a_ev4_maps_chan: assert property (host_req_in.rd && host_req_in.addr == EV4_BASE |=>
    host_rsp_out.data == flag_word($past(event_four_in[0])))
    else $error("event four channel one mismatch");
  a_ev3_rise_off: assert property (s_read_of(CSMB_R_EV3) ##0 event_three_rise_in[chan] |=>
    host_rsp_out.data == WORD_ZERO)
    else $error("event three flag on in rise mode");
  a_out_bits_low: assert property (s_read_of(CSMB_R_OUT) ##0 !host_req_in.digit_mode |=>
    host_rsp_out.data[15:4] == '0)
    else $error("output state upper bits set");
  a_out_digit_form: assert property (s_read_of(CSMB_R_OUT) ##0 host_req_in.digit_mode |=>
    (host_rsp_out.data & 16'hEEEE) == WORD_ZERO)
    else $error("output digit not 0 or 1");
  a_out_time_prop: assert property (s_read_of(CSMB_R_OUT) ##0 (time_prop_in[chan[3:0]] == '0) |=>
    host_rsp_out.data == WORD_ZERO)
    else $error("output bit shown for non time-proportional output");
  a_soak_sec_max: assert property (s_read_of(CSMB_R_SOAK) ##0 (!soak_unit_hm_in[chan] && !host_req_in.digit_mode) |=>
    host_rsp_out.data <= SOAK_MAX_SEC)
    else $error("soak seconds above limit");
  a_soak_min_max: assert property (s_read_of(CSMB_R_SOAK) ##0 (soak_unit_hm_in[chan] && !host_req_in.digit_mode) |=>
    host_rsp_out.data <= SOAK_MAX_MIN)
    else $error("soak minutes above limit");
  a_wr_no_change: assert property (host_req_in.wr && !host_req_in.rd |=>
    host_rsp_out.wr_ignored && $stable(host_rsp_out.data))
    else $error("write changed answer data");
  // answer pulses follow their strobes by exactly one cycle
  a_answer_pulse: assert property (host_rsp_out.valid == $past(host_req_in.rd) &&
    host_rsp_out.wr_ignored == $past(host_req_in.wr))
    else $error("answer pulse not one cycle after strobe");
endmodule

// ---- logic/csmb_pkg.sv ----
// package with address map, field layout and carrier types of the monitor bank
package csmb_pkg;
  localparam int unsigned ADDR_W = 16;                    // modbus word address width
  localparam int unsigned DATA_W = 16;                    // register word width
  // first-channel word address of each monitor region
  localparam logic [15:0] RS_BASE   = 16'h03CC;           // remote setting input monitor
  localparam logic [15:0] OPEN_BASE = 16'h040C;           // sensor open flag
  localparam logic [15:0] EV1_BASE  = 16'h044C;           // event one flag
  localparam logic [15:0] EV2_BASE  = 16'h048C;           // event two flag
  localparam logic [15:0] EV3_BASE  = 16'h04CC;           // event three flag
  localparam logic [15:0] EV4_BASE  = 16'h050C;           // event four flag
  localparam logic [15:0] HBA_BASE  = 16'h054C;           // heater break alarm flag
  localparam logic [15:0] OUT_BASE  = 16'h058C;           // output state bits
  localparam logic [15:0] SOAK_BASE = 16'h059C;           // area soak time monitor
  localparam int unsigned OUT_BITS  = 4;                  // outputs per channel
  localparam int unsigned DIGIT_W   = 4;                  // one decimal digit per nibble
  // soak time limits
  localparam logic [15:0] SOAK_MAX_SEC = 16'h2EDF;        // 11999 seconds
  localparam logic [15:0] SOAK_MAX_MIN = 16'h176F;        // 5999 minutes
  localparam logic [15:0] SOAK_RADIX   = 16'h003C;        // 60 per higher unit
  localparam logic [15:0] DIGIT_SCALE  = 16'h0064;        // upper field times 100
  localparam logic [15:0] WORD_ZERO    = 16'h0000;        // flag off / reserved bits
  localparam logic [15:0] WORD_ONE     = 16'h0001;        // flag on
  // decoded region
  typedef enum logic [3:0] {
    CSMB_R_NONE, CSMB_R_RS, CSMB_R_OPEN, CSMB_R_EV1, CSMB_R_EV2,
    CSMB_R_EV3, CSMB_R_EV4, CSMB_R_HBA, CSMB_R_OUT, CSMB_R_SOAK
  } csmb_region_e;
  // host request carrier
  typedef struct packed {
    logic              rd;                                // read strobe
    logic              wr;                                // write strobe
    logic              digit_mode;                        // 1: digit-string encoding
    logic [ADDR_W-1:0] addr;                              // word address
  } csmb_req_s;
  // answer carrier
  typedef struct packed {
    logic              valid;                             // read data valid pulse
    logic              error;                             // unmapped address pulse
    logic              wr_ignored;                        // write refused pulse
    logic [DATA_W-1:0] data;                              // read data
  } csmb_rsp_s;
endpackage

// ---- sim/csmb_host_model.sv ----
// host-side request driver standing in for the fieldbus master
`timescale 1ns/1ps
module csmb_host_model
  import csmb_pkg::*;
(
  input  wire logic          clock_in, // bank clock
  output csmb_pkg::csmb_req_s req_out  // request toward the bank
);
  initial req_out = '0;
  // present a request now, held until the next rising edge takes it
  task automatic access(input logic rd, input logic wr, input logic dm, input logic [15:0] a);
    req_out = '{rd: rd, wr: wr, digit_mode: dm, addr: a};
    @(posedge clock_in);
    #1;
  endtask
  // drop strobes; the address no longer shows the old value
  task automatic idle();
    req_out = '{rd: 1'b0, wr: 1'b0, digit_mode: ~req_out.digit_mode, addr: ~req_out.addr};
  endtask
endmodule

// ---- sim/channel_state_monitor_bank_tb_top.sv ----
// self-checking bench for the channel monitor bank
`timescale 1ns/1ps
module channel_state_monitor_bank_tb_top;
  import csmb_pkg::*;
  logic               clock_in = 1'b0;   // 25 MHz
  logic               sys_rst_in = 1'b1; // held high at start
  csmb_req_s          req;               // from host model
  csmb_rsp_s          rsp;               // from bank
  logic [63:0][15:0]  rs_v, soak_v;      // per-channel words
  logic [63:0]        open_v, ev1_v, ev2_v, ev3_v, rise_v, ev4_v, hba_v, hm_v;
  logic [15:0][3:0]   on_v, tp_v;        // output levels and types
  logic signed [15:0] lo_v, hi_v;        // limiter pair
  logic [15:0]        prev;              // data before a write
  int                 err_total = 0;
  int                 tests_run = 0;
  int                 cyc = 0;
  int                 c;
  always #20 clock_in = ~clock_in;
  csmb_host_model u_host (.clock_in(clock_in), .req_out(req));
  csmb_bank u_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .host_req_in(req),
    .remote_setting_in(rs_v), .limiter_low_in(lo_v), .limiter_high_in(hi_v),
    .sensor_open_in(open_v), .event_one_in(ev1_v), .event_two_in(ev2_v), .event_three_in(ev3_v),
    .event_three_rise_in(rise_v), .event_four_in(ev4_v), .heater_break_in(hba_v),
    .output_on_in(on_v), .time_prop_in(tp_v), .soak_count_in(soak_v), .soak_unit_hm_in(hm_v),
    .host_rsp_out(rsp));
  // closing report
  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // expected word for an address
  function automatic logic [15:0] exp_word(input logic [15:0] a, input logic dm);
    logic [5:0][63:0] fl;
    logic [15:0]      off;
    logic [3:0]       m;
    int               v;
    int               mx;
    fl = {hba_v, ev4_v, ev3_v & ~rise_v, ev2_v, ev1_v, open_v};
    off = a - RS_BASE;
    if (a >= RS_BASE && off < 16'h01C0) begin
      v = (off < 16'h0040) ? int'($signed(rs_v[off[5:0]])) : 0;
      if (v < lo_v) v = lo_v;
      if (v > hi_v) v = hi_v;
      return (off < 16'h0040) ? 16'(v) : {15'h0000, fl[off[8:6] - 3'h1][off[5:0]]};
    end else if (a >= OUT_BASE && a < SOAK_BASE) begin
      m = on_v[a[3:0] - OUT_BASE[3:0]] & tp_v[a[3:0] - OUT_BASE[3:0]];
      return dm ? {3'h0, m[3], 3'h0, m[2], 3'h0, m[1], 3'h0, m[0]} : {12'h000, m};
    end else if (a >= SOAK_BASE && a < SOAK_BASE + 16'h0040) begin
      v = soak_v[6'(a - SOAK_BASE)];
      mx = hm_v[6'(a - SOAK_BASE)] ? SOAK_MAX_MIN : SOAK_MAX_SEC;
      if (v > mx) v = mx;
      return dm ? 16'((v / SOAK_RADIX) * DIGIT_SCALE + v % SOAK_RADIX) : 16'(v);
    end
    return 16'h0000;
  endfunction
  // one read with its answer checked the cycle after
  task automatic rd_chk(input logic [15:0] a, input logic dm);
    logic mp;
    mp = (a >= RS_BASE) && (a < SOAK_BASE + 16'h0040);
    u_host.access(1'b1, 1'b0, dm, a);
    chk({15'h0000, rsp.valid}, 16'h0001);
    chk({14'h0000, rsp.error, rsp.wr_ignored}, {14'h0000, ~mp, 1'b0});
    chk(rsp.data, exp_word(a, dm));
  endtask
  // cycle ceiling against hangs
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      give_verdict();
    end
  end
  // main sequence
  initial begin
    void'($urandom(15));
    tp_v = '1;
    repeat (16) @(posedge clock_in);
    #1 sys_rst_in = 1'b0;
    chk({13'h0000, rsp.valid, rsp.error, rsp.wr_ignored}, 16'h0000);
    chk(rsp.data, 16'h0000);
    for (int r = 0; r < 6; r++) begin
      for (int i = 0; i < 64; i++) begin
        rs_v[i] = 16'($urandom);
        soak_v[i] = 16'($urandom_range(0, 13000));
      end
      {open_v, ev1_v, ev2_v, ev3_v} = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      {rise_v, ev4_v, hba_v, hm_v} = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      on_v = {$urandom, $urandom};
      tp_v = {$urandom, $urandom};
      tp_v[0] = r[1] ? 4'h0 : 4'hF;
      lo_v = -16'($urandom_range(0, 4000));
      hi_v = 16'($urandom_range(0, 4000));
      hm_v[0] = r[0];
      hm_v[63] = r[0];
      soak_v[0] = r[0] ? SOAK_MAX_MIN : SOAK_MAX_SEC;
      soak_v[63] = soak_v[0] + 16'h0001;
      @(posedge clock_in);
      #1;
      for (int k = 0; k < 8; k++) begin
        c = (k == 0) ? 0 : (k == 1) ? 63 : $urandom_range(0, 63);
        rd_chk(RS_BASE + 16'(c), 1'b0);
        for (int b = 1; b < 7; b++) rd_chk(RS_BASE + 16'(b * 64 + c), 1'b0);
        rd_chk(OUT_BASE + 16'(c % 16), 1'b0);
        rd_chk(OUT_BASE + 16'(c % 16), 1'b1);
        rd_chk(SOAK_BASE + 16'(c), 1'b0);
        rd_chk(SOAK_BASE + 16'(c), 1'b1);
      end
      u_host.idle();
    end
    @(posedge clock_in);
    #1;
    prev = rsp.data;
    u_host.access(1'b0, 1'b1, 1'b0, SOAK_BASE);
    chk({15'h0000, rsp.wr_ignored}, 16'h0001);
    chk(rsp.data, prev);
    chk({15'h0000, rsp.error}, 16'h0000);
    u_host.access(1'b0, 1'b1, 1'b0, 16'h05DC);
    chk({15'h0000, rsp.error}, 16'h0001);
    chk({15'h0000, rsp.wr_ignored}, 16'h0001);
    rd_chk(SOAK_BASE, 1'b0);
    rd_chk(16'h03CB, 1'b0);
    rd_chk(16'h05DC, 1'b0);
    u_host.idle();
    give_verdict();
  end
endmodule
